// ---- rtl/charger_adc_status_map.vh ----
`ifndef CHARGER_ADC_STATUS_MAP_VH
`define CHARGER_ADC_STATUS_MAP_VH

`define ADDR_SYSTEM_VOLTAGE_RESULT 8'h0f
`define ADDR_THERMISTOR_PERCENT_RESULT 8'h10
`define ADDR_BUS_VOLTAGE_RESULT 8'h11
`define ADDR_CHARGE_CURRENT_RESULT 8'h12
`define ADDR_POWER_LIMIT_STATUS 8'h13

`define RESET_RESULT 8'h00
`define CODE_WIDTH 7
`define LIMIT_WIDTH 6

`define BIT_SUPPLY_GOOD 7
`define BIT_VOLTAGE_LIMITING 7
`define BIT_CURRENT_LIMITING 6

`endif

// ---- rtl/result_field.v ----
`include "charger_adc_status_map.vh"

// One result field: captures a whole code on a strobe, so a read never
// sees a half-updated value.
module result_field #(
   parameter WIDTH = 7
) (
   input wire i_clock,
   input wire i_reset,
   input wire i_enable,
   input wire i_load,
   input wire [WIDTH-1:0] i_value,
   output wire [WIDTH-1:0] o_value
);

   reg [WIDTH-1:0] value_ff;
   reg [WIDTH-1:0] nxt_value;

   always @* begin
      nxt_value = value_ff;
      if (i_load) begin
         nxt_value = i_value;
      end
   end

   always @(posedge i_clock) begin
      if (i_reset) begin
         value_ff <= {WIDTH{1'b0}};
      end else if (i_enable) begin
         value_ff <= nxt_value;
      end
   end

   assign o_value = value_ff;

endmodule

// ---- rtl/charger_adc_status_registers.v ----
`include "charger_adc_status_map.vh"

// Five read-only result/status registers. The converter and charger core
// run on i_clock and present whole codes with a load strobe; the status
// flags come from analog comparators and are synchronised here.
module charger_adc_status_registers (
   input wire i_clock,
   input wire i_reset,
   input wire i_enable,
   // Converter results, same clock domain
   input wire i_conversion_done,
   input wire [6:0] i_system_voltage_code,
   input wire [6:0] i_thermistor_percent_code,
   input wire [6:0] i_input_bus_voltage_code,
   input wire [6:0] i_charge_current_code,
   // Charger core, same clock domain
   input wire i_limit_update,
   input wire [5:0] i_optimized_input_limit_code,
   // Comparator levels from the analog side
   input wire i_battery_below_short,
   input wire i_input_supply_good,
   input wire i_input_voltage_limiting_flag,
   input wire i_input_current_limiting_flag,
   // Register access port
   input wire i_read,
   input wire i_write,
   input wire [7:0] i_address,
   input wire [7:0] i_write_data,
   output wire o_read_valid,
   output wire o_address_hit,
   output reg [7:0] o_read_data
);

   ////////////////////////////////////////////////////////////////////////

   reg [3:0] sync1_ff;
   reg [3:0] sync2_ff;
   reg [7:0] read_data_ff;
   reg read_valid_ff;
   reg [7:0] nxt_read_data;

   wire [6:0] system_voltage_code;
   wire [6:0] thermistor_percent_code;
   wire [6:0] input_bus_voltage_code;
   wire [6:0] charge_current_code;
   wire [5:0] optimized_input_limit_code;
   wire [6:0] charge_current_gated;
   wire battery_short;
   wire input_supply_good;
   wire input_voltage_limiting_flag;
   wire input_current_limiting_flag;

   function is_mapped;
      input [7:0] addr;
      begin
         is_mapped = (addr >= `ADDR_SYSTEM_VOLTAGE_RESULT) &&
                     (addr <= `ADDR_POWER_LIMIT_STATUS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers for the asynchronous comparator levels

   always @(posedge i_clock) begin
      if (i_reset) begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
      end else if (i_enable) begin
         sync1_ff <= {i_battery_below_short, i_input_supply_good,
                      i_input_voltage_limiting_flag,
                      i_input_current_limiting_flag};
         sync2_ff <= sync1_ff;
      end
   end

   assign battery_short = sync2_ff[3];
   assign input_supply_good = sync2_ff[2];
   assign input_voltage_limiting_flag = sync2_ff[1];
   assign input_current_limiting_flag = sync2_ff[0];

   ////////////////////////////////////////////////////////////////////////
   // Result fields, each loaded whole on its strobe

   // A short battery forces the code to zero at capture, so the stored
   // result is consistent with the condition seen at conversion time.
   assign charge_current_gated = battery_short ? 7'h00 :
                                 i_charge_current_code;

   result_field #(.WIDTH(7)) u_system_voltage (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_enable(i_enable),
      .i_load(i_conversion_done),
      .i_value(i_system_voltage_code),
      .o_value(system_voltage_code)
   );

   result_field #(.WIDTH(7)) u_thermistor_percent (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_enable(i_enable),
      .i_load(i_conversion_done),
      .i_value(i_thermistor_percent_code),
      .o_value(thermistor_percent_code)
   );

   result_field #(.WIDTH(7)) u_input_bus_voltage (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_enable(i_enable),
      .i_load(i_conversion_done),
      .i_value(i_input_bus_voltage_code),
      .o_value(input_bus_voltage_code)
   );

   result_field #(.WIDTH(7)) u_charge_current (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_enable(i_enable),
      .i_load(i_conversion_done),
      .i_value(charge_current_gated),
      .o_value(charge_current_code)
   );

   result_field #(.WIDTH(6)) u_optimized_limit (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_enable(i_enable),
      .i_load(i_limit_update),
      .i_value(i_optimized_input_limit_code),
      .o_value(optimized_input_limit_code)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read port; writes are accepted on the port but change nothing

   always @* begin
      case (i_address)
         `ADDR_SYSTEM_VOLTAGE_RESULT: begin
            nxt_read_data = {1'b0, system_voltage_code};
         end
         `ADDR_THERMISTOR_PERCENT_RESULT: begin
            nxt_read_data = {1'b0, thermistor_percent_code};
         end
         `ADDR_BUS_VOLTAGE_RESULT: begin
            nxt_read_data = {input_supply_good,
                             input_bus_voltage_code};
         end
         `ADDR_CHARGE_CURRENT_RESULT: begin
            nxt_read_data = {1'b0, charge_current_code};
         end
         `ADDR_POWER_LIMIT_STATUS: begin
            nxt_read_data = {input_voltage_limiting_flag,
                             input_current_limiting_flag,
                             optimized_input_limit_code};
         end
         default: begin
            nxt_read_data = 8'h00;
         end
      endcase
   end

   // Data is captured in one cycle from whole stored fields, so a read
   // cannot straddle a field update.
   always @(posedge i_clock) begin
      if (i_reset) begin
         read_data_ff <= `RESET_RESULT;
         read_valid_ff <= 1'b0;
      end else if (i_enable) begin
         read_valid_ff <= i_read;
         if (i_read) begin
            read_data_ff <= nxt_read_data;
         end
      end
   end

   // i_write and i_write_data are deliberately unused: every bit is
   // read-only.

   always @* begin
      o_read_data = read_data_ff;
   end

   assign o_read_valid = read_valid_ff;
   assign o_address_hit = is_mapped(i_address);

endmodule

// ---- verif/charger_adc_status_monitor.sv ----
module charger_adc_status_monitor (
   input wire i_clock,
   input wire i_reset,
   input wire i_enable,
   input wire i_read,
   input wire [7:0] i_address,
   input wire i_input_supply_good,
   input wire i_input_voltage_limiting_flag,
   input wire i_input_current_limiting_flag,
   input wire o_read_valid,
   input wire o_address_hit,
   input wire [7:0] o_read_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   sequence rd_any;
      i_read && i_enable;
   endsequence
   sequence rd_at(logic [7:0] a);
      rd_any ##0 i_address == a;
   endsequence
   answer_next_a: assert property (rd_any |=> o_read_valid)
      else $error("read not answered");
   idle_hold_a: assert property (i_enable && !i_read |=>
      !o_read_valid && $stable(o_read_data)) else $error("data moved");
   top_zero_a: assert property (rd_any ##0 (i_address == 8'h0f ||
      i_address == 8'h10 || i_address == 8'h12) |=> !o_read_data[7])
      else $error("unused bit set");
   // Flags pass a synchroniser, so only settled levels are judged
   supply_bit_a: assert property (i_input_supply_good[*4] ##0
      rd_at(8'h11) |=> o_read_data[7]) else $error("supply bit low");
   vlim_bit_a: assert property (i_input_voltage_limiting_flag[*4] ##0
      rd_at(8'h13) |=> o_read_data[7]) else $error("voltage flag low");
   ilim_bit_a: assert property ((!i_input_current_limiting_flag)[*4]
      ##0 rd_at(8'h13) |=> !o_read_data[6]) else $error("current flag");
   hit_range_a: assert property (o_address_hit ==
      (i_address >= 8'h0f && i_address <= 8'h13)) else $error("bad hit");
   unmapped_a: assert property (rd_any ##0 !o_address_hit |=>
      o_read_data == 8'h00) else $error("unmapped not zero");
endmodule

// ---- verif/host_reader.sv ----
module host_reader (
   input wire i_clock,
   output logic o_read = 1'h0,
   output logic o_write = 1'h0,
   output logic [7:0] o_address = 8'h00,
   output logic [7:0] o_write_data = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released lines show the inverse so a stale address cannot pass
   task automatic access(input logic w, input logic [7:0] a, d);
      @(posedge i_clock);
      o_read <= !w;
      o_write <= w;
      o_address <= a;
      o_write_data <= d;
      @(posedge i_clock);
      o_read <= 1'h0;
      o_write <= 1'h0;
      o_address <= ~a;
      o_write_data <= ~d;
   endtask
endmodule

// ---- verif/tb_charger_adc_status_registers.sv ----
`define CMP(g, w) begin checks++; if ((g) !== (w)) begin err_count++; \
   $display("unexpected %0t got %h want %h", $time, g, w); end end
module tb_charger_adc_status_registers;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock = 1'h0, i_reset = 1'h1, done = 1'h0, lupd = 1'h0;
   logic en = 1'h1;
   logic bs = 1'h0, sg = 1'h0, vl = 1'h0, cl = 1'h0, rd, wr, valid;
   logic [6:0] sv = 7'h00, ts = 7'h00, bv = 7'h00, cc = 7'h00;
   logic [5:0] lim = 6'h00;
   logic [7:0] ad, wdat, rdat, want;
   logic [7:0] exp_q[$];
   int err_count = 0;
   int checks = 0;
   initial forever #4 i_clock = ~i_clock;
   charger_adc_status_registers dut_u (.i_clock(i_clock), .i_reset(i_reset),
      .i_enable(en), .i_conversion_done(done), .i_limit_update(lupd),
      .i_system_voltage_code(sv), .i_thermistor_percent_code(ts),
      .i_input_bus_voltage_code(bv), .i_charge_current_code(cc),
      .i_optimized_input_limit_code(lim), .i_battery_below_short(bs),
      .i_input_supply_good(sg), .i_input_voltage_limiting_flag(vl),
      .i_input_current_limiting_flag(cl), .i_read(rd), .i_write(wr),
      .i_address(ad), .i_write_data(wdat), .o_read_valid(valid),
      .o_address_hit(), .o_read_data(rdat));
   host_reader host_u (.i_clock(i_clock), .o_read(rd), .o_write(wr),
      .o_address(ad), .o_write_data(wdat));
   //////////
   always @(posedge i_clock) begin
      if (valid) begin
         if (exp_q.size() == 0) `CMP(valid, 1'h0)
         else begin
            want = exp_q.pop_front();
            `CMP(rdat, want)
         end
      end
   end
   task automatic finish_test();
      `CMP(exp_q.size(), 0)
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Reads all five registers and one unmapped address
   task automatic rd_all();
      for (int i = 0; i < 6; i++) begin
         case (i)
            0: exp_q.push_back({1'h0, sv});
            1: exp_q.push_back({1'h0, ts});
            2: exp_q.push_back({sg, bv});
            3: exp_q.push_back({1'h0, bs ? 7'h00 : cc});
            4: exp_q.push_back({vl, cl, lim});
            default: exp_q.push_back(8'h00);
         endcase
         host_u.access(1'h0, 8'h0f + 8'(i), 8'h00);
      end
   endtask
   // Several times the expected run, so only a real hang trips it
   initial begin
      #100000;
      err_count++;
      finish_test();
   end
   initial begin
      void'($urandom(28));
      repeat (6) @(posedge i_clock);
      i_reset <= 1'h0;
      rd_all();
      $display("test reset done");
      // Enable low: a read gets no answer and a load strobe is lost
      @(posedge i_clock);
      en <= 1'h0;
      sv <= 7'h2a;
      done <= 1'h1;
      host_u.access(1'h0, 8'h0f, 8'h00);
      done <= 1'h0;
      sv <= 7'h00;
      en <= 1'h1;
      @(posedge i_clock);
      rd_all();
      $display("test enable done");
      for (int n = 0; n < 24; n++) begin
         @(posedge i_clock);
         {sv, ts, bv, cc} <= 28'($urandom);
         {lim, bs, sg, vl, cl} <= 10'($urandom);
         // Flags settle through the synchroniser before the capture
         repeat (4) @(posedge i_clock);
         done <= 1'h1;
         lupd <= 1'h1;
         @(posedge i_clock);
         done <= 1'h0;
         lupd <= 1'h0;
         rd_all();
         for (int i = 0; i < 6; i++)
            host_u.access(1'h1, 8'h0f + 8'(i), 8'($urandom));
         rd_all();
         $display("test %0d done", n);
      end
      repeat (4) @(posedge i_clock);
      finish_test();
   end
endmodule
bind charger_adc_status_registers charger_adc_status_monitor mon_u (.*);
